// file: lve_exception_logic.sv
`timescale 1ns/1ps
`include "lve_cfg.svh"
module lve_exception_logic
  import lve_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Pipeline
  input wire lve_retire_type retire_i,
  input wire lve_debug_type debug_i,
  // Nonmaskable sources (pin is asynchronous)
  input wire logic nmi_pin_i,
  input wire logic router_nmi_req_i,
  // Dispatch
  output lve_event_type event_o,
  output logic [`LVE_DS_WIDTH-1:0] debug_status_register_o,
  output logic signed_overflow_flag_o,
  output logic carry_flag_o
);
  logic [2:0] nmi_sync;
  logic nmi_level;
  logic nmi_prev;
  logic nmi_pending;
  logic nmi_taken;
  lve_event_type next_event;
  logic [`LVE_DS_WIDTH-1:0] next_status;
  logic [31:0] pc_next;
  logic bound_out;
  logic soft_break;
  logic soft_debug;

  function automatic lve_event_type make_ev(input logic [7:0] vec, input lve_class_type cl,
                                            input logic [31:0] rpc, input logic sup);
    lve_event_type e;
    e.valid = 1'b1;
    e.vector = vec;
    e.ex_class = cl;
    e.code_valid = 1'b0; // None of these vectors push a code
    e.return_pc = rpc;
    e.suppress = sup;
    return e;
  endfunction

  // Three-stage synchroniser; edge counts once stages two and three agree
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      nmi_sync <= 3'h0;
    else
      nmi_sync <= {nmi_sync[1:0], nmi_pin_i};
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      nmi_level <= 1'b0;
    else if (nmi_sync[1] == nmi_sync[2])
      nmi_level <= nmi_sync[2];
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      nmi_prev <= 1'b0;
    else
      nmi_prev <= nmi_level;
  end

  // Latched until a boundary; a new request wins over the taking
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      nmi_pending <= 1'b0;
    else if ((nmi_level && !nmi_prev) || router_nmi_req_i) // see (RULE6)
      nmi_pending <= 1'b1;
    else if (nmi_taken)
      nmi_pending <= 1'b0;
  end

  assign pc_next = retire_i.pc + {28'h0, retire_i.length};
  assign bound_out = (retire_i.bound_index < retire_i.bound_lower) ||
                     (retire_i.bound_index > retire_i.bound_upper); // see (RULE12)
  assign soft_break = retire_i.is_soft_int &&
                      (retire_i.soft_operand == `LVE_SOFT_BREAK_OPERAND); // see (RULE9)
  // Only operand 1 marks the soft bit; other operands must not leave a false cause
  assign soft_debug = retire_i.is_soft_int &&
                      (retire_i.soft_operand == `LVE_SOFT_DEBUG_OPERAND); // see (RULE3)

  // Priority: faults before execution, then traps after, then nonmaskable at the boundary
  always_comb
  begin
    next_event = '0;
    nmi_taken = 1'b0;
    next_status = debug_status_register_o;
    if (retire_i.valid)
    begin
      if (debug_i.fetch_bp || debug_i.detect)
      begin
        next_event = make_ev(`LVE_VEC_DEBUG, LVE_CLASS_FAULT, retire_i.pc, 1'b1); // see (RULE3)
        next_status = '0; // see (RULE4)
        next_status[`LVE_DS_FETCH] = debug_i.fetch_bp;
        next_status[`LVE_DS_DETECT] = debug_i.detect;
      end
      else if (retire_i.is_divide && (retire_i.div_zero || retire_i.div_too_wide)) // see (RULE1)
        next_event = make_ev(`LVE_VEC_DIVIDE, LVE_CLASS_FAULT, retire_i.pc, 1'b1); // see (RULE2)
      else if (retire_i.is_bound && bound_out)
        next_event = make_ev(`LVE_VEC_RANGE, LVE_CLASS_FAULT, retire_i.pc, 1'b1); // see (RULE13)
      else if (retire_i.is_break1 || soft_break)
        next_event = make_ev(`LVE_VEC_BREAK, LVE_CLASS_TRAP, pc_next, 1'b0); // see (RULE8)
      else if (retire_i.is_ovf_check && signed_overflow_flag_o)
        next_event = make_ev(`LVE_VEC_OVERFLOW, LVE_CLASS_TRAP, pc_next, 1'b0); // see (RULE10)
      else if (debug_i.data_bp || debug_i.io_bp || debug_i.step || debug_i.task_sw ||
               soft_debug)
      begin
        next_event = make_ev(`LVE_VEC_DEBUG, LVE_CLASS_TRAP, pc_next, 1'b0); // see (RULE5)
        next_status = '0;
        next_status[`LVE_DS_DATA] = debug_i.data_bp;
        next_status[`LVE_DS_IO] = debug_i.io_bp;
        next_status[`LVE_DS_STEP] = debug_i.step;
        next_status[`LVE_DS_TASK] = debug_i.task_sw;
        next_status[`LVE_DS_SOFT] = soft_debug;
      end
      else if (nmi_pending)
      begin
        next_event = make_ev(`LVE_VEC_NMI, LVE_CLASS_NONE, pc_next, 1'b0); // see (RULE7)
        nmi_taken = 1'b1;
      end
    end
  end

  // Registered event to dispatch
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      event_o <= '0;
    else
      event_o <= next_event; // see (RULE14)
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      debug_status_register_o <= '0;
    else
      debug_status_register_o <= next_status;
  end

  // Arithmetic flags; faulting instructions do not change them
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      signed_overflow_flag_o <= 1'b0;
      carry_flag_o <= 1'b0;
    end
    else if (retire_i.valid && retire_i.is_addsub && !next_event.suppress)
    begin
      signed_overflow_flag_o <= retire_i.alu_ovf; // see (RULE11)
      carry_flag_o <= retire_i.alu_carry;
    end
  end

  // Fault vectors: pointer at the instruction, nothing commits
  a_divide_fault: assert property (@(posedge core_clk_i) // see (RULE1)
    disable iff (!reset_n_i)
    retire_i.valid && retire_i.is_divide && retire_i.div_zero && !debug_i.fetch_bp &&
    !debug_i.detect |=> event_o.vector == `LVE_VEC_DIVIDE &&
    event_o.ex_class == LVE_CLASS_FAULT && event_o.return_pc == $past(retire_i.pc))
    else $error("divide error not raised as fault");
  a_no_error_code: assert property (@(posedge core_clk_i) // see (RULE2)
    disable iff (!reset_n_i)
    event_o.valid |-> !event_o.code_valid)
    else $error("error code flagged");
  // A suppressed instruction must leave the flags as they were
  a_fault_flags: assert property (@(posedge core_clk_i) // see (RULE2)
    disable iff (!reset_n_i)
    event_o.valid && event_o.suppress |-> $stable(signed_overflow_flag_o) &&
    $stable(carry_flag_o))
    else $error("faulting instruction changed the flags");
  // Debug vector: class by condition, cause kept for the handler
  a_fetch_fault: assert property (@(posedge core_clk_i) // see (RULE3)
    disable iff (!reset_n_i)
    retire_i.valid && debug_i.fetch_bp |=> event_o.vector == `LVE_VEC_DEBUG &&
    event_o.suppress && debug_status_register_o[`LVE_DS_FETCH])
    else $error("fetch breakpoint not a fault");
  a_debug_cause: assert property (@(posedge core_clk_i) // see (RULE4)
    disable iff (!reset_n_i)
    event_o.valid && event_o.vector == `LVE_VEC_DEBUG |-> debug_status_register_o != '0)
    else $error("debug event with no cause recorded");
  a_step_trap: assert property (@(posedge core_clk_i) // see (RULE5)
    disable iff (!reset_n_i)
    event_o.valid && event_o.vector == `LVE_VEC_DEBUG && event_o.ex_class == LVE_CLASS_TRAP
    |-> event_o.return_pc == $past(retire_i.pc) + {28'h0, $past(retire_i.length)})
    else $error("debug trap pointer wrong");
  // Nonmaskable: requests are never lost, taken only between instructions
  a_router_nmi: assert property (@(posedge core_clk_i) // see (RULE6)
    disable iff (!reset_n_i)
    router_nmi_req_i |=> nmi_pending)
    else $error("router request lost");
  a_pin_nmi: assert property (@(posedge core_clk_i) // see (RULE6)
    disable iff (!reset_n_i)
    nmi_level && !nmi_prev |=> nmi_pending)
    else $error("pin request lost");
  a_nmi_boundary: assert property (@(posedge core_clk_i) // see (RULE7)
    disable iff (!reset_n_i)
    event_o.vector == `LVE_VEC_NMI && event_o.valid |-> $past(retire_i.valid) &&
    $past(nmi_pending) && event_o.ex_class == LVE_CLASS_NONE &&
    event_o.return_pc == $past(retire_i.pc) + {28'h0, $past(retire_i.length)})
    else $error("nonmaskable taken off boundary");
  // Trap vectors: pointer past the instruction
  a_break_trap: assert property (@(posedge core_clk_i) // see (RULE8)
    disable iff (!reset_n_i)
    retire_i.valid && retire_i.is_break1 && !debug_i.fetch_bp && !debug_i.detect
    |=> event_o.vector == `LVE_VEC_BREAK && event_o.ex_class == LVE_CLASS_TRAP)
    else $error("breakpoint not trapped");
  a_ovf_trap: assert property (@(posedge core_clk_i) // see (RULE10)
    disable iff (!reset_n_i)
    retire_i.valid && retire_i.is_ovf_check && signed_overflow_flag_o && !retire_i.is_divide &&
    !retire_i.is_bound && !retire_i.is_break1 && !retire_i.is_soft_int && !debug_i.fetch_bp &&
    !debug_i.detect |=> event_o.vector == `LVE_VEC_OVERFLOW &&
    event_o.return_pc == $past(retire_i.pc) + {28'h0, $past(retire_i.length)})
    else $error("overflow check with flag set did not trap");
  a_ovf_quiet: assert property (@(posedge core_clk_i) // see (RULE10)
    disable iff (!reset_n_i)
    retire_i.valid && retire_i.is_ovf_check && !signed_overflow_flag_o
    |=> event_o.vector != `LVE_VEC_OVERFLOW || !event_o.valid)
    else $error("overflow trap with flag clear");
  // Range check: an index under the lower limit must fault
  a_range_trip: assert property (@(posedge core_clk_i) // see (RULE12)
    disable iff (!reset_n_i)
    retire_i.valid && retire_i.is_bound && !retire_i.is_divide && !debug_i.fetch_bp &&
    !debug_i.detect && (retire_i.bound_index < retire_i.bound_lower)
    |=> event_o.valid && event_o.vector == `LVE_VEC_RANGE &&
    event_o.ex_class == LVE_CLASS_FAULT)
    else $error("index below the lower limit not faulted");
  a_range_fault: assert property (@(posedge core_clk_i) // see (RULE13)
    disable iff (!reset_n_i)
    event_o.valid && event_o.vector == `LVE_VEC_RANGE |-> event_o.suppress &&
    event_o.return_pc == $past(retire_i.pc))
    else $error("range fault pointer wrong");
  a_idle_quiet: assert property (@(posedge core_clk_i) // see (RULE14)
    disable iff (!reset_n_i)
    !retire_i.valid |=> !event_o.valid)
    else $error("event without a retiring instruction");
endmodule

// file: lve_cfg.svh
// Operation
// (RULE1) Zero divisor or quotient overflow raises vector 0
// (RULE2) Divide error: no code, pointer at divide
// (RULE3) Vector 1: fetch/detect faults, others traps
// (RULE4) Debug: no code, cause into status register
// (RULE5) Debug fault points here, trap points next
// (RULE6) Pin or router request raises vector 2
// (RULE7) Nonmaskable taken at boundary, pointer next
// (RULE8) One-byte breakpoint: vector 3 trap, next
// (RULE9) Software interrupt operand 3 raises vector 3
// (RULE10) Overflow check traps vector 4 if flag
// (RULE11) Add/subtract update overflow and carry flags
// (RULE12) Index outside limits raises vector 5 fault
// (RULE13) Range fault keeps operands, restarts instruction
// (RULE14) Report vector, class and code-valid to dispatch
`ifndef LVE_CFG_SVH
`define LVE_CFG_SVH
`define LVE_VEC_DIVIDE 8'h00
`define LVE_VEC_DEBUG 8'h01
`define LVE_VEC_NMI 8'h02
`define LVE_VEC_BREAK 8'h03
`define LVE_VEC_OVERFLOW 8'h04
`define LVE_VEC_RANGE 8'h05
`define LVE_SOFT_BREAK_OPERAND 8'h03
`define LVE_SOFT_DEBUG_OPERAND 8'h01
`define LVE_BREAK_LEN 4'h1
// Debug status bit positions
`define LVE_DS_FETCH 0
`define LVE_DS_DATA 1
`define LVE_DS_IO 2
`define LVE_DS_DETECT 3
`define LVE_DS_STEP 4
`define LVE_DS_TASK 5
`define LVE_DS_SOFT 6
`define LVE_DS_WIDTH 7
`endif

// file: lve_pkg.sv
package lve_pkg;
  typedef enum logic [1:0] {LVE_CLASS_FAULT, LVE_CLASS_TRAP, LVE_CLASS_NONE} lve_class_type;
  // One retiring instruction as seen by the exception logic
  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic [3:0] length;
    logic is_divide;
    logic div_zero;
    logic div_too_wide;
    logic is_break1;
    logic is_soft_int;
    logic [7:0] soft_operand;
    logic is_ovf_check;
    logic is_bound;
    logic signed [31:0] bound_index;
    logic signed [31:0] bound_lower;
    logic signed [31:0] bound_upper;
    logic is_addsub;
    logic alu_ovf;
    logic alu_carry;
  } lve_retire_type;
  // Debug conditions reported by the breakpoint units
  typedef struct packed {
    logic fetch_bp;
    logic data_bp;
    logic io_bp;
    logic detect;
    logic step;
    logic task_sw;
  } lve_debug_type;
  // Event handed to dispatch
  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    lve_class_type ex_class;
    logic code_valid;
    logic [31:0] return_pc;
    logic suppress;
  } lve_event_type;
endpackage

// file: lve_pipe_model.sv
`timescale 1ns/1ps
module lve_pipe_model
  import lve_pkg::*;
(
  // Commands from the bench
  input wire logic go_i,
  input wire lve_retire_type cmd_i,
  input wire lve_debug_type dbg_i,
  // Towards the exception logic
  output lve_retire_type retire_o,
  output lve_debug_type debug_o
);
  // Between retires every field but valid flips, so stale values cannot pass for live ones
  always_comb
  begin
    retire_o = go_i ? cmd_i : ~cmd_i;
    retire_o.valid = go_i;
    debug_o = go_i ? dbg_i : ~dbg_i;
  end
endmodule

// file: test_lve_exception_logic.sv
`timescale 1ns/1ps
module test_lve_exception_logic;
  import lve_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic go = 1'b0;
  logic nmi_pin = 1'b0;
  logic router_req = 1'b0;
  lve_retire_type cmd = '0;
  lve_debug_type dbg = '0;
  lve_retire_type retire;
  lve_debug_type debug;
  lve_event_type ev;
  logic [6:0] status;
  logic ovf;
  logic carry;
  int failures = 0;
  int check_count = 0;
  lve_retire_type r;
  // Clock at 200 MHz
  always #2.5 core_clk_i = ~core_clk_i;
  lve_pipe_model lve_pipe_model_inst (.go_i(go), .cmd_i(cmd), .dbg_i(dbg), .retire_o(retire),
    .debug_o(debug));
  lve_exception_logic lve_exception_logic_inst (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .retire_i(retire), .debug_i(debug), .nmi_pin_i(nmi_pin), .router_nmi_req_i(router_req),
    .event_o(ev), .debug_status_register_o(status), .signed_overflow_flag_o(ovf),
    .carry_flag_o(carry));
  task finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function lve_retire_type mk(input logic [31:0] pc);
    mk = '0;
    mk.valid = 1'b1;
    mk.pc = pc;
    mk.length = 4'h3;
  endfunction
  // One retire cycle; returns on the falling edge where the answer stands
  task run(input lve_retire_type x, input lve_debug_type d);
    @(negedge core_clk_i);
    cmd = x;
    dbg = d;
    go = 1'b1;
    @(negedge core_clk_i);
    go = 1'b0;
  endtask
  task chk(input logic [7:0] v, input lve_class_type c, input logic [31:0] p, input logic s);
    check_count++;
    if (ev.valid !== 1'b1 || ev.vector !== v || ev.ex_class !== c || ev.return_pc !== p ||
        ev.suppress !== s || ev.code_valid !== 1'b0)
    begin
      failures++;
      $display("unexpected event at %0t: vector %h", $time, ev.vector);
    end
  endtask
  task chk_none;
    check_count++;
    if (ev.valid !== 1'b0)
    begin
      failures++;
      $display("unexpected spurious event at %0t", $time);
    end
  endtask
  task chk_val(input logic [6:0] got, input logic [6:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task t_divide;
    r = mk(32'h0000_0100);
    r.is_divide = 1'b1;
    r.div_zero = 1'b1;
    run(r, '0);
    chk(8'h00, LVE_CLASS_FAULT, 32'h0000_0100, 1'b1);
    r.div_zero = 1'b0;
    r.div_too_wide = 1'b1;
    run(r, '0);
    chk(8'h00, LVE_CLASS_FAULT, 32'h0000_0100, 1'b1);
    r.div_too_wide = 1'b0;
    run(r, '0);
    chk_none();
  endtask
  // Fetch and detect are faults, the rest traps
  task t_debug;
    for (int i = 0; i < 6; i++)
    begin
      run(mk(32'h0000_0200), lve_debug_type'(6'h20 >> i));
      if (i == 0 || i == 3)
        chk(8'h01, LVE_CLASS_FAULT, 32'h0000_0200, 1'b1);
      else
        chk(8'h01, LVE_CLASS_TRAP, 32'h0000_0203, 1'b0);
      chk_val(status, 7'(1 << i));
    end
    r = mk(32'h0000_0210);
    r.is_soft_int = 1'b1;
    r.soft_operand = 8'h01;
    run(r, '0);
    chk(8'h01, LVE_CLASS_TRAP, 32'h0000_0213, 1'b0);
    chk_val(status, 7'h40);
  endtask
  task t_break;
    r = mk(32'h0000_0300);
    r.is_break1 = 1'b1;
    r.length = 4'h1;
    run(r, '0);
    chk(8'h03, LVE_CLASS_TRAP, 32'h0000_0301, 1'b0);
    r = mk(32'h0000_0310);
    r.is_soft_int = 1'b1;
    r.soft_operand = 8'h03;
    r.length = 4'h2;
    run(r, '0);
    chk(8'h03, LVE_CLASS_TRAP, 32'h0000_0312, 1'b0);
  endtask
  // Flags from an add feed the later overflow check
  task t_flags;
    for (int i = 0; i < 2; i++)
    begin
      r = mk(32'h0000_0400);
      r.is_addsub = 1'b1;
      r.alu_ovf = (i == 0);
      r.alu_carry = (i == 1);
      run(r, '0);
      chk_val({5'h00, ovf, carry}, (i == 0) ? 7'h02 : 7'h01);
      r = mk(32'h0000_0410);
      r.is_ovf_check = 1'b1;
      run(r, '0);
      if (i == 0)
        chk(8'h04, LVE_CLASS_TRAP, 32'h0000_0413, 1'b0);
      else
        chk_none();
    end
  endtask
  task t_bound(input logic signed [31:0] idx, input logic hit);
    r = mk(32'h0000_0500);
    r.is_bound = 1'b1;
    r.bound_index = idx;
    r.bound_lower = 32'sh0000_0000;
    r.bound_upper = 32'sh0000_000a;
    run(r, '0);
    if (hit)
      chk(8'h05, LVE_CLASS_FAULT, 32'h0000_0500, 1'b1);
    else
      chk_none();
  endtask
  // Router request waits behind two divide faults; the pin needs a few edges to land
  task t_nmi;
    @(negedge core_clk_i);
    router_req = 1'b1;
    @(negedge core_clk_i);
    router_req = 1'b0;
    r = mk(32'h0000_0100);
    r.is_divide = 1'b1;
    r.div_zero = 1'b1;
    run(r, '0);
    chk(8'h00, LVE_CLASS_FAULT, 32'h0000_0100, 1'b1);
    r.div_zero = 1'b0;
    r.div_too_wide = 1'b1;
    run(r, '0);
    chk(8'h00, LVE_CLASS_FAULT, 32'h0000_0100, 1'b1);
    run(mk(32'h0000_0600), '0);
    chk(8'h02, LVE_CLASS_NONE, 32'h0000_0603, 1'b0);
    run(mk(32'h0000_0610), '0);
    chk_none();
    nmi_pin = 1'b1;
    repeat (6) @(negedge core_clk_i);
    nmi_pin = 1'b0;
    run(mk(32'h0000_0700), '0);
    chk(8'h02, LVE_CLASS_NONE, 32'h0000_0703, 1'b0);
  endtask
  // Watchdog well beyond the fewer than a hundred cycles the tests need
  initial
  begin
    #20000;
    failures++;
    finish_test();
  end
  initial
  begin
    repeat (16) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    t_divide();
    t_debug();
    t_break();
    t_flags();
    t_bound(-32'sd1, 1'b1);
    t_bound(32'sd11, 1'b1);
    t_bound(32'sd10, 1'b0);
    t_bound(32'sd0, 1'b0);
    t_nmi();
    finish_test();
  end
endmodule
